// ===== dsi_consts.svh
// Purpose: Shared constants for the sensor-bus command block and its master
// Assumes: 50 MHz clock, 20-bit long-word frames with a 4-bit check field
// Notes:   Definitions only
`ifndef DSI_CONSTS_SVH
`define DSI_CONSTS_SVH

// Frame word layout: data[19:12] addr[11:8] opcode[7:4] check[3:0]
`define W_DATA_LSB      12
`define W_ADDR_LSB      8
`define W_OP_LSB        4
`define W_CRC_LSB       0
`define W_BODY_LSB      4

// Bits inside the reverse-initialization data byte
`define RI_NV_BIT       7
`define RI_BS_BIT       6

// Opcodes
`define OP_CLEAR        4'h7
`define OP_CLR_LO       4'hc
`define OP_SET_LO       4'hd
`define OP_RINIT        4'hf

// Check field generator
`define CRC_POLY        4'h3
`define CRC_SEED        4'ha

// Fault test time and its cycle count at the clock rate
`define CLK_MHZ         50
`define FAULT_TEST_US   200
`define FAULT_TEST_CYC  (`FAULT_TEST_US * `CLK_MHZ)

// Master side
`define FRAME_GAP_CYC   8
`define REG_CMD         12'h000
`define REG_STAT        12'h004
`define REG_RSP         12'h008
`define CMD_LONG_BIT    16
`define ST_BUSY_BIT     0
`define ST_RSP_BIT      1
`define ST_CRCERR_BIT   2
`define ST_NORSP_BIT    3

`endif

// ===== dsi_crc4.sv
// Purpose: Four-bit check value over a 16-bit frame body, MSB first
// Assumes: Polynomial and seed from the constants header
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_crc4 (
    input  wire logic [15:0] i_data,
    output logic      [3:0]  o_crc
);
    always_comb begin
        logic [3:0] c;
        logic       fb;
        fb = 1'b0;
        c  = `CRC_SEED;
        for (int i = 15; i >= 0; i--) begin
            fb = c[3] ^ i_data[i];
            c  = {c[2:0], 1'b0} ^ ({4{fb}} & `CRC_POLY);
        end
        o_crc = c;
    end
endmodule

// ===== dsi_link_assertions.sv
// Purpose: Checks on the frame link between bus master and slave
// Assumes: Both ends on i_clk; reply to frame N-1 travels with frame N
// Notes:   Check field is recomputed here, independent of the design
`timescale 1ns/1ps
module dsi_link_assertions (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        cmd_valid,
    input wire logic        cmd_long,
    input wire logic [19:0] cmd_word,
    input wire logic        rsp_valid,
    input wire logic [19:0] rsp_word
);
    ////////////////////////////////////////////////////////////////////////
    // Frame before the current one; bit 20 holds its long-word flag
    logic [20:0] cur_q;
    logic [20:0] prev_q;

    function automatic logic [3:0] chk4(input logic [15:0] d);
        logic [3:0] c;
        logic       fb;
        c = 4'ha;
        for (int i = 15; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'h0} ^ (fb ? 4'h3 : 4'h0);
        end
        return c;
    endfunction

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_q  <= 21'h0;
            prev_q <= 21'h0;
        end else if (cmd_valid) begin
            cur_q  <= {cmd_long, cmd_word};
            prev_q <= cur_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    reply_slot_a: assert property (
        rsp_valid |-> $past(cmd_valid))
        else $error("reply outside the slot after a frame");
    cmd_check_a: assert property (
        cmd_valid |-> cmd_word[3:0] == chk4(cmd_word[19:4]))
        else $error("command check field wrong");
    reply_check_a: assert property (
        rsp_valid |-> rsp_word[3:0] == chk4(rsp_word[19:4]))
        else $error("reply check field wrong");
    zero_addr_a: assert property (
        rsp_valid |-> prev_q[11:8] != 4'h0
            && rsp_word[19:16] == prev_q[11:8])
        else $error("reply to address zero or wrong address");
    bad_frame_a: assert property (
        rsp_valid |-> prev_q[3:0] == chk4(prev_q[19:4]))
        else $error("reply to a corrupted frame");
    long_only_a: assert property (
        rsp_valid |-> prev_q[20])
        else $error("reply to a short word");
    status_fmt_a: assert property (
        rsp_valid && prev_q[7:5] == 3'h6 |->
            rsp_word[15:12] == 4'h0 && rsp_word[9] == prev_q[4])
        else $error("status reply layout wrong");
    rinit_fmt_a: assert property (
        rsp_valid && prev_q[7:4] == 4'hf |->
            rsp_word[15:13] == 3'h0 && rsp_word[9:8] == 2'h0
            && rsp_word[7:4] == prev_q[15:12]
            && rsp_word[11:10] == prev_q[19:18])
        else $error("init reply layout wrong");

    cover property (rsp_valid && prev_q[7:5] == 3'h6);
    cover property (rsp_valid && prev_q[7:4] == 4'hf);
    cover property (cmd_valid && !cmd_long);
endmodule

// ===== dsi_link_if.sv
// Purpose: Frame-level link between bus master and slave
// Assumes: Both ends on i_clk; one frame per cmd_valid pulse
// Notes:   Response to frame N is returned while frame N+1 is sent
`timescale 1ns/1ps
interface dsi_link_if;
    logic        cmd_valid;
    logic        cmd_long;
    logic [19:0] cmd_word;
    logic        rsp_valid;
    logic [19:0] rsp_word;

    modport master (
        output cmd_valid,
        output cmd_long,
        output cmd_word,
        input  rsp_valid,
        input  rsp_word
    );

    modport slave (
        input  cmd_valid,
        input  cmd_long,
        input  cmd_word,
        output rsp_valid,
        output rsp_word
    );
endinterface

// ===== dsi_master.sv
// Purpose: Bus master that sends frames on APB orders and keeps replies
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   One frame in flight; writes to the command word while busy drop
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_master #(
    parameter int unsigned FRAME_GAP_CYC = `FRAME_GAP_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    dsi_link_if.master       link,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr
);
    import dsi_pkg::*;

    localparam logic [7:0] GAP_LAST = 8'(FRAME_GAP_CYC);

    host_state_t q;
    host_state_t d;
    logic [3:0]  tx_crc;
    logic [3:0]  rx_crc;
    logic        access;
    logic        setup;

    dsi_crc4 u_tx_crc (
        .i_data (i_pwdata[15:0]),
        .o_crc  (tx_crc)
    );

    dsi_crc4 u_rx_crc (
        .i_data (link.rsp_word[19:`W_BODY_LSB]),
        .o_crc  (rx_crc)
    );

    assign setup  = i_psel && !i_penable;
    assign access = i_psel && i_penable && q.pready;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d           = q;
        d.cmd_valid = 1'b0;
        d.await_rsp = q.cmd_valid;
        d.pready    = setup;
        d.pslverr   = 1'b0;

        if (q.busy) begin
            if (q.gap_cnt == 8'h00) begin
                d.busy = 1'b0;
            end else begin
                d.gap_cnt = q.gap_cnt - 8'h01;
            end
        end

        // Reply slot of the frame just sent belongs to the frame before
        if (q.await_rsp) begin
            d.rsp_got = link.rsp_valid;
            d.no_rsp  = !link.rsp_valid;
            d.rsp_word = link.rsp_word;
            d.crc_err = link.rsp_valid &&
                        (rx_crc != link.rsp_word[`W_CRC_LSB +: 4]);
        end

        // Read data and error are latched in the setup cycle
        if (setup) begin
            d.pslverr = !(i_paddr == `REG_CMD || i_paddr == `REG_STAT ||
                          i_paddr == `REG_RSP);
            unique case (i_paddr)
                `REG_CMD:  d.prdata = {15'h0000, q.cmd_long,
                                       q.cmd_word[19:`W_BODY_LSB]};
                `REG_STAT: d.prdata = {28'h0000000, q.no_rsp, q.crc_err,
                                       q.rsp_got, q.busy};
                `REG_RSP:  d.prdata = {12'h000, q.rsp_word};
                default:   d.prdata = 32'h00000000;
            endcase
        end else begin
            d.pslverr = q.pslverr && !access;
        end

        if (access && i_pwrite && i_paddr == `REG_CMD && !q.busy) begin
            d.cmd_valid = 1'b1;
            d.cmd_long  = i_pwdata[`CMD_LONG_BIT];
            d.cmd_word  = {i_pwdata[15:0], tx_crc};
            d.busy      = 1'b1;
            d.gap_cnt   = GAP_LAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.cmd_valid = q.cmd_valid;
    assign link.cmd_long  = q.cmd_long;
    assign link.cmd_word  = q.cmd_word;
    assign o_prdata       = q.prdata;
    assign o_pready       = q.pready;
    assign o_pslverr      = q.pslverr;

endmodule

// ===== dsi_pkg.sv
// Purpose: Types shared by both ends of the sensor bus
// Assumes: dsi_consts.svh
// Notes:   State machines use one-hot codes
package dsi_pkg;

    typedef enum logic [1:0] {
        FT_IDLE = 2'b01,
        FT_RUN  = 2'b10
    } ftest_state_t;

    typedef enum logic [2:0] {
        PEND_NONE   = 3'b001,
        PEND_STATUS = 3'b010,
        PEND_RINIT  = 3'b100
    } pend_t;

    typedef struct packed {
        logic [3:0]   addr;
        logic         inited;
        logic         nvm_write_permit;
        logic         bus_switch_ctrl;
        logic         sw_closed;
        logic         bus_fault_flag;
        logic         logic_output_level;
        ftest_state_t ft;
        logic [15:0]  ft_cnt;
        pend_t        pend;
        logic [3:0]   io_s1;
        logic [3:0]   io_s2;
        logic         uv_s1;
        logic         uv_s2;
        logic         bus_s1;
        logic         bus_s2;
        logic         prog_s1;
        logic         prog_s2;
        logic         rsp_valid;
        logic [19:0]  rsp_word;
    } dev_state_t;

    typedef struct packed {
        logic         busy;
        logic [7:0]   gap_cnt;
        logic         cmd_valid;
        logic         cmd_long;
        logic [19:0]  cmd_word;
        logic         await_rsp;
        logic [19:0]  rsp_word;
        logic         rsp_got;
        logic         crc_err;
        logic         no_rsp;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } host_state_t;

endpackage

// ===== dsi_slave.sv
// Purpose: Slave command decoder for logic-out, clear and reverse init
// Assumes: Frames arrive as whole words from logic on the same clock
// Notes:   Only long-word frames are decoded; short words still carry out the pending reply
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_slave #(
    parameter int unsigned FAULT_TEST_CYC = `FAULT_TEST_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    dsi_link_if.slave        link,
    input  wire logic [3:0]  i_io_pins,
    input  wire logic        i_undervoltage,
    input  wire logic        i_upstream_bus_pin,
    input  wire logic        i_nvm_programmed,
    output logic             o_logic_out,
    output logic             o_bus_switch_closed,
    output logic             o_fault_test_pull,
    output logic             o_nvm_write_permit,
    output logic [3:0]       o_address
);
    import dsi_pkg::*;

    localparam dev_state_t DEV_RST = '{
        ft:      FT_IDLE,
        pend:    PEND_NONE,
        default: '0
    };
    localparam logic [15:0] FT_LAST = 16'(FAULT_TEST_CYC - 1);

    dev_state_t  q;
    dev_state_t  d;
    logic [15:0] cmd_body;
    logic [3:0]  cmd_crc;
    logic [15:0] status_body;
    logic [15:0] rinit_body;
    logic [3:0]  status_crc;
    logic [3:0]  rinit_crc;
    logic [3:0]  c_addr;
    logic [3:0]  c_op;
    logic [7:0]  c_data;
    logic        frame_ok;

    ////////////////////////////////////////////////////////////////////////
    // Frame fields and check values

    assign cmd_body = link.cmd_word[19:`W_BODY_LSB];
    assign c_addr   = link.cmd_word[`W_ADDR_LSB +: 4];
    assign c_op     = link.cmd_word[`W_OP_LSB +: 4];
    assign c_data   = link.cmd_word[`W_DATA_LSB +: 8];

    // Replies are built from live state at send time so the fault flag and
    // switch position reflect a fault test that ran between the two frames
    assign status_body = {q.addr, 4'h0,
                          q.nvm_write_permit,
                          q.uv_s2,
                          q.logic_output_level,
                          q.sw_closed,
                          q.io_s2};
    assign rinit_body  = {q.addr, 3'b000, q.bus_fault_flag,
                          q.nvm_write_permit, q.bus_switch_ctrl,
                          2'b00,
                          q.addr};

    dsi_crc4 u_cmd_crc (
        .i_data (cmd_body),
        .o_crc  (cmd_crc)
    );

    dsi_crc4 u_status_crc (
        .i_data (status_body),
        .o_crc  (status_crc)
    );

    dsi_crc4 u_rinit_crc (
        .i_data (rinit_body),
        .o_crc  (rinit_crc)
    );

    // Short words carry no usable reverse init, so they are not decoded, though they still carry out the pending reply
    assign frame_ok = link.cmd_long &&
                      (cmd_crc == link.cmd_word[`W_CRC_LSB +: 4]);

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d           = q;
        d.rsp_valid = 1'b0;

        // Pins are asynchronous to the clock
        d.io_s1   = i_io_pins;
        d.io_s2   = q.io_s1;
        d.uv_s1   = i_undervoltage;
        d.uv_s2   = q.uv_s1;
        d.bus_s1  = i_upstream_bus_pin;
        d.bus_s2  = q.bus_s1;
        d.prog_s1 = i_nvm_programmed;
        d.prog_s2 = q.prog_s1;

        // Bus fault test: pull the inactive side down and watch it
        unique case (q.ft)
            FT_IDLE: begin
                d.ft_cnt = '0;
            end
            FT_RUN: begin
                if (q.bus_s2) begin
                    d.bus_fault_flag = 1'b1;
                    d.ft             = FT_IDLE;
                end else if (q.ft_cnt == FT_LAST) begin
                    d.sw_closed = 1'b1;
                    d.ft        = FT_IDLE;
                end else begin
                    d.ft_cnt = q.ft_cnt + 16'h0001;
                end
            end
        endcase

        if (link.cmd_valid) begin
            // Reply to the previous frame goes out with this one
            unique case (q.pend)
                PEND_NONE: begin
                    d.rsp_word = '0;
                end
                PEND_STATUS: begin
                    d.rsp_valid = 1'b1;
                    d.rsp_word  = {status_body, status_crc};
                end
                PEND_RINIT: begin
                    d.rsp_valid = 1'b1;
                    d.rsp_word  = {rinit_body, rinit_crc};
                end
            endcase
            // A bad frame leaves nothing pending for the next slot
            d.pend = PEND_NONE;

            if (frame_ok) begin
                unique case (c_op)
                    `OP_CLEAR: begin
                        if (c_addr == 4'h0 || c_addr == q.addr) begin
                            d         = DEV_RST;
                            d.io_s1   = i_io_pins;
                            d.io_s2   = q.io_s1;
                            d.uv_s1   = i_undervoltage;
                            d.uv_s2   = q.uv_s1;
                            d.bus_s1  = i_upstream_bus_pin;
                            d.bus_s2  = q.bus_s1;
                            d.prog_s1 = i_nvm_programmed;
                            d.prog_s2 = q.prog_s1;
                            d.rsp_valid = q.pend != PEND_NONE;
                            d.rsp_word  = q.pend == PEND_STATUS ?
                                          {status_body, status_crc} :
                                          q.pend == PEND_RINIT ?
                                          {rinit_body, rinit_crc} : '0;
                            d.logic_output_level = 1'b0;
                        end
                    end
                    `OP_CLR_LO, `OP_SET_LO: begin
                        if (c_addr != 4'h0 && c_addr == q.addr) begin
                            d.logic_output_level =
                                (c_op == `OP_SET_LO);
                            d.pend = PEND_STATUS;
                        end
                    end
                    `OP_RINIT: begin
                        // Either the zero address or the repeated address
                        if (!q.inited &&
                            (c_addr == 4'h0 ||
                             c_addr == c_data[3:0])) begin
                            d.inited = 1'b1;
                            d.addr   = c_data[3:0];
                            if (c_data[3:0] != 4'h0) begin
                                d.nvm_write_permit =
                                    c_data[`RI_NV_BIT];
                                d.bus_switch_ctrl  =
                                    c_data[`RI_BS_BIT];
                                if (c_data[`RI_BS_BIT]) begin
                                    d.ft     = FT_RUN;
                                    d.ft_cnt = '0;
                                end
                            end
                            if (c_addr != 4'h0) begin
                                d.pend = PEND_RINIT;
                            end
                        end
                    end
                    default: begin
                        d.pend = PEND_NONE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops, except o_nvm_write_permit, which gates two of them

    assign link.rsp_valid      = q.rsp_valid;
    assign link.rsp_word       = q.rsp_word;
    assign o_logic_out         = q.logic_output_level;
    assign o_bus_switch_closed = q.sw_closed;
    assign o_fault_test_pull   = q.ft[1];
    // Once a permanent address exists the permit has no effect
    assign o_nvm_write_permit  = q.nvm_write_permit & ~q.prog_s2;
    assign o_address           = q.addr;

endmodule

// ===== tb.sv
// Purpose: Master and slave joined back to back, driven over APB
// Assumes: Fault test shortened to 20 cycles; zero-wait APB slave
// Notes:   Reply contents are checked one frame late, as they arrive
`timescale 1ns/1ps
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module tb;
    logic        clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  io_pins;
    logic        uv;
    logic        upstream;
    logic        nvm_prog;
    logic        lo;
    logic        sw;
    logic        pull;
    logic        permit;
    logic [3:0]  addr;
    logic [31:0] r;
    logic        e;
    int          failures;
    int          compares;

    ////////////////////////////////////////////////////////////////////////
    dsi_link_if u_dsi_link_if ();
    dsi_master #(.FRAME_GAP_CYC(8)) u_dsi_master (
        .i_clk(clk), .i_rst_n(rst_n), .link(u_dsi_link_if),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr));
    dsi_slave #(.FAULT_TEST_CYC(20)) u_dsi_slave (
        .i_clk(clk), .i_rst_n(rst_n), .link(u_dsi_link_if),
        .i_io_pins(io_pins), .i_undervoltage(uv),
        .i_upstream_bus_pin(upstream), .i_nvm_programmed(nvm_prog),
        .o_logic_out(lo), .o_bus_switch_closed(sw),
        .o_fault_test_pull(pull), .o_nvm_write_permit(permit),
        .o_address(addr));
    dsi_link_assertions u_dsi_link_assertions (
        .i_clk(clk), .i_rst_n(rst_n),
        .cmd_valid(u_dsi_link_if.cmd_valid),
        .cmd_long(u_dsi_link_if.cmd_long),
        .cmd_word(u_dsi_link_if.cmd_word),
        .rsp_valid(u_dsi_link_if.rsp_valid),
        .rsp_word(u_dsi_link_if.rsp_word));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
    endtask

    // Sends one frame, then checks the reply it brought back
    task automatic step(input logic [15:0] body, input logic lng,
                        input logic has, input logic [15:0] exp);
        int n;
        apb(1'h1, 12'h000, {15'h0, lng, body}, r, e);
        n = 0;
        do begin
            apb(1'h0, 12'h004, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'h0 && n < 50);
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
        `CHK(r[1], has)
        `CHK(r[3:2], {!has, 1'h0})
        apb(1'h0, 12'h008, 32'h0, r, e);
        if (has) `CHK(r[19:4], exp) else `CHK(r, 32'h0)
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        compares = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        io_pins  = 4'ha;
        uv       = 1'h1;
        upstream = 1'h0;
        nvm_prog = 1'h0;
        rst_n    = 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        `CHK(lo, 1'h0)
        step(16'hc50f, 1'h1, 1'h0, 16'h0);
        `CHK(pull, 1'h1)
        repeat (30) @(posedge clk);
        `CHK(addr, 4'h5)
        `CHK(sw, 1'h1)
        `CHK(permit, 1'h1)
        nvm_prog <= 1'h1;
        repeat (4) @(posedge clk);
        `CHK(permit, 1'h0)
        nvm_prog <= 1'h0;
        done("init");
        step(16'h005d, 1'h1, 1'h0, 16'h0);
        `CHK(lo, 1'h1)
        step(16'h005c, 1'h1, 1'h1, 16'h50fa);
        `CHK(lo, 1'h0)
        step(16'h055f, 1'h1, 1'h1, 16'h50da);
        `CHK(addr, 4'h5)
        done("logic_out");
        // Wrong address, short word, address zero
        step(16'h003d, 1'h1, 1'h0, 16'h0);
        step(16'h005d, 1'h0, 1'h0, 16'h0);
        step(16'h000d, 1'h1, 1'h0, 16'h0);
        `CHK(lo, 1'h0)
        step(16'h005d, 1'h1, 1'h0, 16'h0);
        // New pin levels must show up in the reply, not a stale copy
        io_pins <= 4'h3;
        step(16'h003d, 1'h1, 1'h1, 16'h50f3);
        step(16'h0057, 1'h1, 1'h0, 16'h0);
        `CHK(lo, 1'h0)
        `CHK(sw, 1'h0)
        `CHK(addr, 4'h0)
        `CHK(permit, 1'h0)
        done("refusals");
        // Init again after the clear, this time into a shorted bus
        upstream <= 1'h1;
        step(16'h466f, 1'h1, 1'h0, 16'h0);
        repeat (30) @(posedge clk);
        `CHK(sw, 1'h0)
        `CHK(pull, 1'h0)
        `CHK(addr, 4'h6)
        step(16'h006d, 1'h1, 1'h1, 16'h6146);
        upstream <= 1'h0;
        done("fault");
        apb(1'h0, 12'h00c, 32'h0, r, e);
        `CHK(r, 32'h0)
        `CHK(e, 1'h1)
        apb(1'h0, 12'h000, 32'h0, r, e);
        `CHK(r[16:0], 17'h1006d)
        done("regs");
        // Global clear returns the pending reply, then init at address zero
        step(16'h0007, 1'h1, 1'h1, 16'h6063);
        step(16'hc00f, 1'h1, 1'h0, 16'h0);
        `CHK(pull, 1'h0)
        `CHK(sw, 1'h0)
        `CHK(permit, 1'h0)
        `CHK(addr, 4'h0)
        done("global");
        wrap_up();
    end
endmodule
